/* File: hw/aopc_top.sv */
// aopc_top: result-port configuration for an 18-bit sampling converter.
// assumes the conversion core runs on clk_i and pulses conv_done_i with a
// straight-binary result; pins from the host side arrive asynchronously.
// How it works
// - mode field picks 18-bit, 16-bit, byte bus, or serial output.
// - coding high gives straight binary; low inverts msb for twos complement.
// - 18-bit mode drives bit 1 on shared pin; in 16-bit and byte modes it selects format.
// - 18-bit mode drives bit 2 on second shared pin.
// - byte mode makes second shared pin a format select input; 16-bit mode reads only the first.
// - bit 3 pin is always an output; carries bit 3 in parallel modes.
// - master read-after-convert sets serial clock period from divide setting.
// - master read-after-convert caps busy at 2.55/3.40/5.00/8.20 us.
// - clock source low drives own serial clock; high follows external clock.
// - in master mode, read mode low shifts current result after; high previous during.
//
// Design decisions made here: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
module aopc_top (
   input wire logic clk_i,
   input wire logic rstn_i,
   // avalon-mm slave
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // conversion core
   input wire logic [aopc_pkg::RES_W-1:0] conv_result_i,
   input wire logic conv_done_i,
   // host pins
   input wire logic convert_start_strobe_n_i,
   input wire logic chip_select_n_i,
   input wire logic serial_data_clock_i,
   output logic serial_data_clock_o,
   output logic serial_data_clock_oe_o,
   output logic serial_result_out_o,
   output logic serial_result_out_oe_o,
   output logic busy_o,
   input wire logic bit1_or_format_select_low_i,
   output logic bit1_or_format_select_low_o,
   output logic bit1_or_format_select_low_oe_o,
   input wire logic bit2_or_format_select_high_i,
   output logic bit2_or_format_select_high_o,
   output logic bit2_or_format_select_high_oe_o,
   output logic result_bit3_o,
   output logic [aopc_pkg::RES_W-1:4] result_bus_o,
   output logic [aopc_pkg::RES_W-1:4] result_bus_oe_o,
   output logic result_bit0_o,
   output logic result_bit0_oe_o
);
   import aopc_pkg::*;

   typedef enum logic [1:0] {
      AOPC_IDLE = 2'b00,
      AOPC_CONV = 2'b01,
      AOPC_SHIFT = 2'b10
   } aopc_state_t;

   // two-flop synchronisers for all pin inputs
   logic [PIN_W-1:0] pin_meta_q, pin_sync_q, pin_prev_q;
   logic [PIN_W-1:0] pin_raw;
   assign pin_raw = {bit2_or_format_select_high_i, bit1_or_format_select_low_i, chip_select_n_i,
                     serial_data_clock_i, convert_start_strobe_n_i};
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pin_meta_q <= PIN_RST;
         pin_sync_q <= PIN_RST;
         pin_prev_q <= PIN_RST;
      end else begin
         pin_meta_q <= pin_raw;
         pin_sync_q <= pin_meta_q;
         pin_prev_q <= pin_sync_q;
      end
   end
   logic cnv_fall, xclk_rise, cs_low;
   assign cnv_fall = pin_prev_q[PIN_CNV] & ~pin_sync_q[PIN_CNV];
   assign xclk_rise = ~pin_prev_q[PIN_XCLK] & pin_sync_q[PIN_XCLK];
   assign cs_low = ~pin_sync_q[PIN_CS];

   // software-visible control and bus slave state
   logic [CTRL_W-1:0] ctrl_q, ctrl_d;
   logic wait_q, wait_d;
   logic [31:0] rdata_q, rdata_d;
   aopc_mode_t mode;
   logic coding, ext_clk, read_during_convert_select;
   logic [1:0] div_sel;
   assign mode = aopc_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
   assign coding = ctrl_q[CTRL_CODING];
   assign div_sel = ctrl_q[CTRL_DIV_LSB +: 2];
   assign ext_clk = ctrl_q[CTRL_EXT];
   assign read_during_convert_select = ctrl_q[CTRL_RDC];

   // conversion and shift state
   aopc_state_t state_q, state_d;
   logic [RES_W-1:0] res_q, res_d, sh_q, sh_d;
   logic valid_q, valid_d, busy_q, busy_d, shifting_q, shifting_d;
   logic [4:0] bits_q, bits_d;
   logic [2:0] ph_q, ph_d;
   logic [7:0] bcnt_q, bcnt_d;
   logic sclk_q, sclk_d, sdo_q, sdo_d;

   logic ser_mode, master, rac;
   assign ser_mode = (mode == AOPC_MODE_SER);
   assign master = ser_mode & ~ext_clk;
   assign rac = master & ~read_during_convert_select;

   // divide setting to period and busy limit
   logic [2:0] per;
   logic [7:0] busy_lim;
   always_comb begin
      unique case (div_sel)
         2'b00: begin
            per = 3'(SCLK_CYC0);
            busy_lim = 8'(BUSY_CYC0);
         end
         2'b01: begin
            per = 3'(SCLK_CYC1);
            busy_lim = 8'(BUSY_CYC1);
         end
         2'b10: begin
            per = 3'(SCLK_CYC2);
            busy_lim = 8'(BUSY_CYC2);
         end
         2'b11: begin
            per = 3'(SCLK_CYC3);
            busy_lim = 8'(BUSY_CYC3);
         end
      endcase
   end

   // coded result: core delivers straight binary
   logic [RES_W-1:0] coded;
   assign coded = {res_q[RES_W-1] ^ ~coding, res_q[RES_W-2:0]};

   // register bus: one wait cycle, then answer; writes land on the answer edge
   always_comb begin
      ctrl_d = ctrl_q;
      wait_d = 1'b1;
      rdata_d = rdata_q;
      if ((avs_read_i | avs_write_i) & wait_q) begin
         wait_d = 1'b0;
         unique case (avs_address_i)
            REG_CTRL: rdata_d = {25'h0, ctrl_q};
            REG_STAT: rdata_d = {29'h0, valid_q, shifting_q, busy_q};
            REG_RES: rdata_d = {14'h0, coded};
            default: rdata_d = 32'h0;
         endcase
      end
      if (avs_write_i & ~wait_q & (avs_address_i == REG_CTRL)) begin
         ctrl_d = avs_writedata_i[CTRL_W-1:0]; // software keeps it static
      end
   end
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl_q <= CTRL_RST;
         wait_q <= 1'b1;
         rdata_q <= 32'h0;
      end else begin
         ctrl_q <= ctrl_d;
         wait_q <= wait_d;
         rdata_q <= rdata_d;
      end
   end

   // conversion sequencing, busy and the serial shifter
   always_comb begin
      state_d = state_q;
      res_d = res_q;
      sh_d = sh_q;
      valid_d = valid_q;
      busy_d = busy_q;
      shifting_d = shifting_q;
      bits_d = bits_q;
      ph_d = ph_q;
      bcnt_d = bcnt_q;
      sclk_d = 1'b0;
      sdo_d = sdo_q;
      if (busy_q) begin
         bcnt_d = bcnt_q + 8'h01;
      end
      // master clock: low half then high half; data moves at period start
      if (master & shifting_q) begin
         ph_d = (ph_q == per - 3'h1) ? 3'h0 : ph_q + 3'h1;
         sclk_d = (ph_d >= (per >> 1));
         if (ph_q == per - 3'h1) begin
            if (bits_q == 5'(RES_W - 1)) begin
               shifting_d = 1'b0;
               ph_d = 3'h0;
               sclk_d = 1'b0;
            end else begin
               bits_d = bits_q + 5'h01;
               sh_d = {sh_q[RES_W-2:0], 1'b0};
               sdo_d = sh_q[RES_W-2];
            end
         end
      end
      // slave: shift on external clock while chip select is low
      if (ser_mode & ext_clk & cs_low & xclk_rise) begin
         sh_d = {sh_q[RES_W-2:0], 1'b0};
         sdo_d = sh_q[RES_W-2];
      end
      unique case (state_q)
         AOPC_IDLE: begin
            if (cnv_fall) begin
               state_d = AOPC_CONV;
               busy_d = 1'b1;
               bcnt_d = 8'h00;
               if (master & read_during_convert_select) begin // previous result during conversion
                  sh_d = coded;
                  sdo_d = coded[RES_W-1];
                  shifting_d = valid_q;
                  bits_d = 5'h00;
                  ph_d = 3'h0;
               end
            end
         end
         AOPC_CONV: begin
            if (conv_done_i) begin
               res_d = conv_result_i;
               valid_d = 1'b1;
               if (rac) begin // current result after conversion
                  state_d = AOPC_SHIFT;
                  sh_d = {conv_result_i[RES_W-1] ^ ~coding, conv_result_i[RES_W-2:0]};
                  sdo_d = conv_result_i[RES_W-1] ^ ~coding;
                  shifting_d = 1'b1;
                  bits_d = 5'h00;
                  ph_d = 3'h0;
               end else begin
                  state_d = AOPC_IDLE;
                  busy_d = 1'b0;
                  if (ser_mode & ext_clk) begin
                     sh_d = {conv_result_i[RES_W-1] ^ ~coding, conv_result_i[RES_W-2:0]};
                     sdo_d = conv_result_i[RES_W-1] ^ ~coding;
                  end
               end
            end
         end
         AOPC_SHIFT: begin
            if (~shifting_q) begin
               state_d = AOPC_IDLE;
               busy_d = 1'b0;
            end
         end
         default: state_d = AOPC_IDLE;
      endcase
      // hard cap on busy in read-after-convert; a late shift is cut short
      if (rac & busy_q & (bcnt_q >= busy_lim - 8'h01)) begin
         state_d = AOPC_IDLE;
         busy_d = 1'b0;
         shifting_d = 1'b0;
         sclk_d = 1'b0;
      end
   end
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_q <= AOPC_IDLE;
         res_q <= 18'h00000;
         sh_q <= 18'h00000;
         valid_q <= 1'b0;
         busy_q <= 1'b0;
         shifting_q <= 1'b0;
         bits_q <= 5'h00;
         ph_q <= 3'h0;
         bcnt_q <= 8'h00;
         sclk_q <= 1'b0;
         sdo_q <= 1'b0;
      end else begin
         state_q <= state_d;
         res_q <= res_d;
         sh_q <= sh_d;
         valid_q <= valid_d;
         busy_q <= busy_d;
         shifting_q <= shifting_d;
         bits_q <= bits_d;
         ph_q <= ph_d;
         bcnt_q <= bcnt_d;
         sclk_q <= sclk_d;
         sdo_q <= sdo_d;
      end
   end

   // parallel word selection; format selects are read only where they are inputs
   logic [1:0] fmt;
   logic [RES_W-1:0] word;
   assign fmt = {pin_sync_q[PIN_FHI], pin_sync_q[PIN_FLO]};
   always_comb begin
      word = coded;
      unique case (mode)
         AOPC_MODE_P18: word = coded;
         AOPC_MODE_P16: word = fmt[0] ? {2'b00, coded[1:0], 14'h0000} : {2'b00, coded[RES_W-1:2]};
         AOPC_MODE_P8: begin
            unique case (fmt)
               2'b00: word = {10'h000, coded[17:10]};
               2'b01: word = {10'h000, coded[9:2]};
               2'b10: word = {10'h000, coded[1:0], 6'h00};
               2'b11: word = 18'h00000;
            endcase
         end
         AOPC_MODE_SER: word = 18'h00000;
      endcase
   end

   // pin drivers, all registered
   logic par, p18;
   assign par = ~ser_mode;
   assign p18 = (mode == AOPC_MODE_P18);
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         avs_readdata_o <= 32'h0;
         avs_waitrequest_o <= 1'b1;
         busy_o <= 1'b0;
         serial_data_clock_o <= 1'b0;
         serial_data_clock_oe_o <= 1'b0;
         serial_result_out_o <= 1'b0;
         serial_result_out_oe_o <= 1'b0;
         result_bit0_o <= 1'b0;
         result_bit0_oe_o <= 1'b0;
         bit1_or_format_select_low_o <= 1'b0;
         bit1_or_format_select_low_oe_o <= 1'b0;
         bit2_or_format_select_high_o <= 1'b0;
         bit2_or_format_select_high_oe_o <= 1'b0;
         result_bit3_o <= 1'b0;
         result_bus_o <= 14'h0000;
         result_bus_oe_o <= 14'h0000;
      end else begin
         avs_readdata_o <= rdata_d;
         avs_waitrequest_o <= wait_d;
         busy_o <= busy_d;
         serial_data_clock_o <= sclk_d;
         serial_data_clock_oe_o <= master;
         serial_result_out_o <= sdo_d;
         serial_result_out_oe_o <= master | (ser_mode & ext_clk & cs_low);
         result_bit0_o <= word[0];
         result_bit0_oe_o <= par;
         bit1_or_format_select_low_o <= word[1];
         bit1_or_format_select_low_oe_o <= p18;
         bit2_or_format_select_high_o <= word[2];
         bit2_or_format_select_high_oe_o <= p18;
         result_bit3_o <= par & word[3];
         result_bus_o <= word[RES_W-1:4];
         result_bus_oe_o <= {14{par}};
      end
   end
endmodule // aopc_top

/* File: hw/aopc_pkg.sv */
// aopc_pkg: constants for the converter result-port configuration block.
// assumes a single 25 MHz system clock; all timing counts derive from it.
package aopc_pkg;
   localparam int CLK_NS = 40;
   localparam int RES_W = 18;
   // interface modes
   typedef enum logic [1:0] {
      AOPC_MODE_P18 = 2'b00,
      AOPC_MODE_P16 = 2'b01,
      AOPC_MODE_P8 = 2'b10,
      AOPC_MODE_SER = 2'b11
   } aopc_mode_t;
   // register byte addresses (word index in address[3:2])
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h4;
   localparam logic [3:0] REG_RES = 4'h8;
   // control field positions and reset value
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_CODING = 2;
   localparam int CTRL_DIV_LSB = 3;
   localparam int CTRL_EXT = 5;
   localparam int CTRL_RDC = 6;
   localparam int CTRL_W = 7;
   localparam logic [6:0] CTRL_RST = 7'h04;
   // status field positions
   localparam int STAT_BUSY = 0;
   localparam int STAT_SHIFT = 1;
   localparam int STAT_VALID = 2;
   // serial clock minimum periods in ns per divide setting
   localparam int SCLK_MIN_NS0 = 30;
   localparam int SCLK_MIN_NS1 = 60;
   localparam int SCLK_MIN_NS2 = 120;
   localparam int SCLK_MIN_NS3 = 240;
   // even cycle count, at least 2, rounded up from the minimum period
   localparam int SCLK_CYC0 = 2 * ((SCLK_MIN_NS0 + 2 * CLK_NS - 1) / (2 * CLK_NS));
   localparam int SCLK_CYC1 = 2 * ((SCLK_MIN_NS1 + 2 * CLK_NS - 1) / (2 * CLK_NS));
   localparam int SCLK_CYC2 = 2 * ((SCLK_MIN_NS2 + 2 * CLK_NS - 1) / (2 * CLK_NS));
   localparam int SCLK_CYC3 = 2 * ((SCLK_MIN_NS3 + 2 * CLK_NS - 1) / (2 * CLK_NS));
   // longest busy time in ns per divide setting, rounded down to cycles
   localparam int BUSY_MAX_NS0 = 2550;
   localparam int BUSY_MAX_NS1 = 3400;
   localparam int BUSY_MAX_NS2 = 5000;
   localparam int BUSY_MAX_NS3 = 8200;
   localparam int BUSY_CYC0 = BUSY_MAX_NS0 / CLK_NS;
   localparam int BUSY_CYC1 = BUSY_MAX_NS1 / CLK_NS;
   localparam int BUSY_CYC2 = BUSY_MAX_NS2 / CLK_NS;
   localparam int BUSY_CYC3 = BUSY_MAX_NS3 / CLK_NS;
   // pin synchroniser vector positions
   localparam int PIN_CNV = 0;
   localparam int PIN_XCLK = 1;
   localparam int PIN_CS = 2;
   localparam int PIN_FLO = 3;
   localparam int PIN_FHI = 4;
   localparam int PIN_W = 5;
   localparam logic [4:0] PIN_RST = 5'h07;
endpackage

/* File: sim/aopc_top_chk.sv */
// aopc_top_chk: concurrent checks on the result-port block's pins and bus.
// assumes control changes only through the avalon port, seen as a shadow copy.
`timescale 1ns/10ps
module aopc_top_chk
   import aopc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic serial_data_clock_o,
   input wire logic serial_data_clock_oe_o,
   input wire logic busy_o,
   input wire logic bit1_or_format_select_low_oe_o,
   input wire logic bit2_or_format_select_high_oe_o,
   input wire logic result_bit3_o,
   input wire logic [RES_W-1:4] result_bus_oe_o,
   input wire logic result_bit0_oe_o
);
   localparam int PER [4] = '{SCLK_CYC0, SCLK_CYC1, SCLK_CYC2, SCLK_CYC3};
   localparam int CAP [4] = '{BUSY_CYC0, BUSY_CYC1, BUSY_CYC2, BUSY_CYC3};
   logic [6:0] sh_d, sh_q, c1_q, c2_q;
   logic [9:0] bc_d, bc_q;
   logic [3:0] sc_d, sc_q;
   logic sk_q, calm, rac, rise;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // two stages of delay so registered pins have caught up with a new setting;
   // the stages reset unequal so the first edges after reset are not judged
   assign calm = (sh_q == c1_q) && (c1_q == c2_q);
   assign rac = calm && c2_q[1:0] == 2'b11 && !c2_q[5] && !c2_q[6];
   assign rise = serial_data_clock_o && !sk_q;
   // busy length and clock spacing; spacing saturates so the first rise is skipped
   always_comb begin
      sh_d = sh_q;
      if (avs_write_i && !avs_waitrequest_o && avs_address_i == REG_CTRL) begin
         sh_d = avs_writedata_i[6:0];
      end
      bc_d = busy_o ? bc_q + 10'h001 : 10'h000;
      sc_d = rise ? 4'h1 : (sc_q == 4'hf ? sc_q : sc_q + 4'h1);
   end
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sh_q <= CTRL_RST;
         c1_q <= ~CTRL_RST;
         c2_q <= ~CTRL_RST;
         bc_q <= 10'h000;
         sc_q <= 4'hf;
         sk_q <= 1'b0;
      end else begin
         sh_q <= sh_d;
         c1_q <= sh_q;
         c2_q <= c1_q;
         bc_q <= bc_d;
         sc_q <= sc_d;
         sk_q <= serial_data_clock_o;
      end
   end
   a_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |-> ##[1:2] !avs_waitrequest_o)
      else $error("bus request not answered in time");
   a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");
   a_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o && !(avs_address_i inside {4'h0, 4'h4, 4'h8})
      |-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
   a_bus_oe_mode: assert property (calm |-> (&result_bus_oe_o) == (c2_q[1:0] != 2'b11)
      && result_bit0_oe_o == (c2_q[1:0] != 2'b11)) else $error("bus enables wrong for mode");
   a_bit1_pin: assert property (calm |-> bit1_or_format_select_low_oe_o == (c2_q[1:0] == 2'b00))
      else $error("bit1 pin direction wrong");
   a_bit2_pin: assert property (calm |-> bit2_or_format_select_high_oe_o == (c2_q[1:0] == 2'b00))
      else $error("bit2 pin direction wrong");
   a_bit3_serial: assert property (calm && c2_q[1:0] == 2'b11 |-> !result_bit3_o)
      else $error("bit3 pin not quiet in serial mode");
   a_master_clk: assert property (calm && c2_q[1:0] == 2'b11 |-> serial_data_clock_oe_o == !c2_q[5])
      else $error("serial clock drive wrong for source");
   a_sclk_period: assert property (rac && rise && sc_q != 4'hf |-> sc_q == PER[c2_q[4:3]])
      else $error("serial clock period wrong");
   a_busy_cap: assert property (rac |-> bc_q <= CAP[c2_q[4:3]])
      else $error("busy longer than cap");
   c_write_ctrl: cover property (avs_write_i && !avs_waitrequest_o && avs_address_i == REG_CTRL);
   c_rac_busy: cover property (rac && $rose(busy_o));
   c_sclk_rise: cover property (rac && rise && sc_q != 4'hf);
endmodule // aopc_top_chk

bind aopc_top aopc_top_chk u_chk (.clk_i, .rstn_i, .avs_address_i, .avs_read_i, .avs_write_i,
   .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .serial_data_clock_o, .serial_data_clock_oe_o,
   .busy_o, .bit1_or_format_select_low_oe_o, .bit2_or_format_select_high_oe_o, .result_bit3_o,
   .result_bus_oe_o, .result_bit0_oe_o);

/* File: sim/aopc_host.sv */
// aopc_host: host model that starts conversions and gathers serial results.
// assumes the device drives the serial clock in master mode; the external
// clock runs, with chip select low, only while xrun_i is high.
`timescale 1ns/10ps
module aopc_host (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic start_i,
   input wire logic xrun_i,
   input wire logic sclk_i,
   input wire logic sclk_oe_i,
   input wire logic sdo_i,
   input wire logic sdo_oe_i,
   output logic strobe_n_o,
   output logic cs_n_o,
   output logic xclk_o,
   output logic [17:0] word_o,
   output logic [5:0] nbits_o
);
   logic sk_q;
   logic [2:0] xc_q;
   // one-cycle start pulse is well above the minimum width
   assign strobe_n_o = !start_i;
   // slow external clock leaves room for the device's pin synchroniser
   assign cs_n_o = !xrun_i;
   assign xclk_o = xc_q[2];
   // either clock's rising edge carries each bit, msb first
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         word_o <= '0;
         nbits_o <= 6'h00;
         sk_q <= 1'b0;
         xc_q <= 3'h0;
      end else begin
         sk_q <= sclk_i;
         xc_q <= xrun_i ? xc_q + 3'h1 : 3'h0;
         if (start_i) begin
            word_o <= '0;
            nbits_o <= 6'h00;
         end else if (sdo_oe_i && ((sclk_oe_i && sclk_i && !sk_q) || (xrun_i && xc_q == 3'h3))) begin
            word_o <= {word_o[16:0], sdo_i};
            nbits_o <= nbits_o + 6'h01;
         end
      end
   end
endmodule // aopc_host

/* File: sim/tb_aopc_top.sv */
// tb_aopc_top: register, parallel and serial result checks for aopc_top.
// assumes the host model in aopc_host.sv and the bound checker.
`timescale 1ns/10ps
module tb_aopc_top;
   import aopc_pkg::*;
   localparam int CAPS [4] = '{BUSY_CYC0, BUSY_CYC1, BUSY_CYC2, BUSY_CYC3};
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [3:0] avs_address_i = 4'h0;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [31:0] avs_readdata_o, rd;
   logic [RES_W-1:0] conv_result_i = '0;
   logic conv_done_i = 1'b0;
   logic start_q = 1'b0;
   logic [1:0] fmt_q = 2'b00;
   logic xrun_q = 1'b0;
   logic avs_waitrequest_o, convert_start_strobe_n_i, chip_select_n_i, serial_data_clock_i, xclk;
   logic serial_data_clock_o, serial_data_clock_oe_o, serial_result_out_o, serial_result_out_oe_o, busy_o;
   logic bit1_or_format_select_low_i, bit1_or_format_select_low_o, bit1_or_format_select_low_oe_o;
   logic bit2_or_format_select_high_i, bit2_or_format_select_high_o, bit2_or_format_select_high_oe_o;
   logic result_bit3_o, result_bit0_o, result_bit0_oe_o;
   logic [RES_W-1:4] result_bus_o, result_bus_oe_o;
   logic [17:0] word;
   logic [5:0] nbits;
   int checked = 0;
   int miscompares = 0;
   int bw;
   always #20 clk_i = ~clk_i;
   // shared pins resolve to whichever side enables its driver
   assign bit1_or_format_select_low_i = bit1_or_format_select_low_oe_o ? bit1_or_format_select_low_o : fmt_q[0];
   assign bit2_or_format_select_high_i = bit2_or_format_select_high_oe_o ? bit2_or_format_select_high_o : fmt_q[1];
   assign serial_data_clock_i = serial_data_clock_oe_o ? serial_data_clock_o : xclk;
   aopc_top u_dut (.*);
   aopc_host u_host (.clk_i(clk_i), .rstn_i(rstn_i), .start_i(start_q), .xrun_i(xrun_q), .sclk_i(serial_data_clock_o),
      .sclk_oe_i(serial_data_clock_oe_o), .sdo_i(serial_result_out_o), .sdo_oe_i(serial_result_out_oe_o),
      .strobe_n_o(convert_start_strobe_n_i), .cs_n_o(chip_select_n_i), .xclk_o(xclk), .word_o(word),
      .nbits_o(nbits));
   function automatic logic [17:0] code(input logic [17:0] v, input logic c);
      return c ? v : v ^ 18'h20000;
   endfunction
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // request held until waitrequest is sampled low, then released
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      avs_write_i <= w;
      avs_read_i <= !w;
      avs_address_i <= a;
      avs_writedata_i <= d;
      do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask
   // strobe, late core result, then count every cycle busy is seen high
   task automatic convert(input logic [17:0] v, input int dly);
      start_q <= 1'b1;
      @(posedge clk_i);
      start_q <= 1'b0;
      while (busy_o !== 1'b1) @(posedge clk_i);
      bw = 1;
      repeat (dly) @(posedge clk_i);
      conv_result_i <= v;
      conv_done_i <= 1'b1;
      @(posedge clk_i);
      conv_done_i <= 1'b0;
      bw += dly;
      while (busy_o === 1'b1) begin
         bw++;
         @(posedge clk_i);
      end
      @(posedge clk_i);
   endtask
   task automatic final_report;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // hang guard, generous against under a thousand cycles of traffic
   initial begin
      repeat (20000) @(posedge clk_i);
      miscompares++;
      final_report();
   end
   initial begin
      repeat (10) @(posedge clk_i);
      rstn_i <= 1'b1;
      bus(1'b0, REG_CTRL, 32'h0);
      check("ctrl reset", rd, {25'h0, CTRL_RST});
      bus(1'b1, 4'hc, 32'hffffffff);
      bus(1'b0, 4'hc, 32'h0);
      check("unmapped", rd, 32'h0);
      // every mode, serial one with external clock source
      for (int m = 0; m < 4; m++) begin
         bus(1'b1, REG_CTRL, 32'h4 | m | (m == 3 ? 32'h20 : 32'h0));
         bus(1'b0, REG_CTRL, 32'h0);
         check("ctrl mode", rd[1:0], m);
         check("pin enables", {bit1_or_format_select_low_oe_o, bit2_or_format_select_high_oe_o, result_bit0_oe_o,
            &result_bus_oe_o, serial_data_clock_oe_o}, m == 0 ? 5'h1e : (m == 3 ? 5'h00 : 5'h06));
      end
      // 18-bit bus in twos complement then straight binary
      for (int c = 0; c < 2; c++) begin
         bus(1'b1, REG_CTRL, c << 2);
         convert(18'h2a5c3 + c, 5);
         check("parallel pins", {result_bus_o, result_bit3_o, bit2_or_format_select_high_o,
            bit1_or_format_select_low_o, result_bit0_o}, code(18'h2a5c3 + c, c));
         bus(1'b1, REG_RES, 32'h0);
         bus(1'b0, REG_RES, 32'h0);
         check("result reg", rd, code(18'h2a5c3 + c, c));
      end
      // byte bus, middle byte picked by the format pins
      bus(1'b1, REG_CTRL, 32'h6);
      fmt_q <= 2'b01;
      bus(1'b0, REG_STAT, 32'h0);
      check("status idle", rd, 32'h4);
      repeat (2) @(posedge clk_i);
      check("byte pins", {result_bus_o, result_bit3_o, result_bit0_o}, 16'h001d);
      // serial master read after convert at each divide setting
      for (int d = 0; d < 4; d++) begin
         bus(1'b1, REG_CTRL, 32'h3 | (d << 3) | ((d & 1) << 2));
         convert(18'h1b7e4 - d, 4);
         check("serial word", word, code(18'h1b7e4 - d, d & 1));
         check("serial count", nbits, 32'h12);
         check("busy width", bw <= CAPS[d], 1'b1);
      end
      convert(18'h3c3c3, 150);
      check("busy capped", bw <= CAPS[3], 1'b1);
      // read during convert shifts the previous result
      bus(1'b1, REG_CTRL, 32'h47);
      convert(18'h0f00f, 60);
      check("previous word", word, 18'h3c3c3);
      bus(1'b0, REG_RES, 32'h0);
      check("new result", rd, 18'h0f00f);
      // slave: host clocks the result out itself while chip select is low
      bus(1'b1, REG_CTRL, 32'h27);
      convert(18'h2d2d1, 4);
      xrun_q <= 1'b1;
      repeat (144) @(posedge clk_i);
      xrun_q <= 1'b0;
      check("slave word", word, 18'h2d2d1);
      check("slave count", nbits, 32'h12);
      final_report();
   end
endmodule // tb_aopc_top
